// *** logic/dmrc_demux_clock.sv ***
// demux rate selection, data-ready clock generation and time-aligned reset path
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1 - half rate splits samples across two ports
// RULE2 - sample clock rising edge times everything
// RULE3 - outputs change only at data-ready rise; at full rate they change every cycle with the clock held high
// RULE4 - reset input sampled on sample clock edge
// RULE5 - undriven reset input means reset inactive
// RULE6 - asserted reset holds demux phase in reset
// RULE7 - reset: latch, pipeline, clock generator, driver
// RULE8 - reset pipeline matches data conversion latency
// RULE9 - reset output aligns with matching data
// RULE10 - drive reset output for external demuxes
// RULE11 - generator makes full, half, quarter clocks; at full rate the clock is held high instead
// RULE12 - unreset half clock phase is arbitrary
// RULE13 - sync reset forces divider known phase
// RULE14 - controller resets all interleaved converters
// RULE15 - split and rate select pick mode
// RULE16 - half rate: auxiliary older, primary newer
// RULE17 - quarter rate drops every other sample
// RULE18 - reset out one cycle before primary
module dmrc_demux_clock
  import dmrc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [SAMPLE_W-1:0] sample_in, // converted sample, one per clk, same domain
  input wire logic sync_reset_in, // active high, asynchronous pin
  input wire logic split_enable, // static pin
  input wire logic rate_select, // static pin
  output logic [SAMPLE_W-1:0] primary_data,
  output logic [SAMPLE_W-1:0] aux_data,
  output logic data_ready_clock_out,
  output logic data_ready_strobe,
  output logic aligned_reset_out
);
  // pin synchronisers; first flops read only by the second and the reset lead check
  logic rst_s1_ff, rst_s2_ff, split_s1_ff, split_s2_ff, rate_s1_ff, rate_s2_ff;
  logic nxt_rst_s1, nxt_rst_s2, nxt_split_s1, nxt_split_s2, nxt_rate_s1, nxt_rate_s2;
  dmrc_mode_t mode_ff, nxt_mode; // registered mode
  logic mode_chg; // pins disagree with registered mode

  // divider and output clock state
  logic [1:0] div_cnt_ff, nxt_div_cnt;
  logic dr_clk_ff, nxt_dr_clk;
  logic upd; // this edge is a data-ready rise, or any edge at full rate
  logic rst_pipe; // reset after pipeline, entering clock generator
  logic rst_out_ff, nxt_rst_out;

  // data path state
  logic [SAMPLE_W-1:0] dly_out; // sample after conversion pipeline
  logic [SAMPLE_W-1:0] prev1_ff, prev2_ff, nxt_prev1, nxt_prev2;
  logic [SAMPLE_W-1:0] prim_ff, aux_ff, nxt_prim, nxt_aux;
  logic strobe_ff, nxt_strobe;

  // check helper: cycles since last reset or mode change
  logic [2:0] quiet_ff, nxt_quiet;

  // synchroniser and mode next values
  always_comb begin
    nxt_rst_s1 = sync_reset_in; // [RULE4]
    nxt_rst_s2 = rst_s1_ff;
    nxt_split_s1 = split_enable;
    nxt_split_s2 = split_s1_ff;
    nxt_rate_s1 = rate_select;
    nxt_rate_s2 = rate_s1_ff;
    nxt_mode = dmrc_decode_mode(split_s2_ff, rate_s2_ff); // [RULE15]
    mode_chg = (nxt_mode != mode_ff);
  end

  // all flops sit on the rising sample clock edge [RULE2]
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
      split_s1_ff <= 1'b0;
      split_s2_ff <= 1'b0;
      rate_s1_ff <= 1'b0;
      rate_s2_ff <= 1'b0;
      mode_ff <= DMRC_FULL;
    end else begin
      rst_s1_ff <= nxt_rst_s1;
      rst_s2_ff <= nxt_rst_s2;
      split_s1_ff <= nxt_split_s1;
      split_s2_ff <= nxt_split_s2;
      rate_s1_ff <= nxt_rate_s1;
      rate_s2_ff <= nxt_rate_s2;
      mode_ff <= nxt_mode;
    end
  end

  // latched reset delayed to line up with converted data [RULE7] [RULE8] [RULE9] [RULE18]
  dmrc_delay_line #(.W(1), .N(RST_PIPE_STAGES)) u_rst_pipe (
    .clk(clk),
    .nrst(nrst),
    .din(rst_s2_ff),
    .dout(rst_pipe)
  );

  // conversion latency of samples ahead of the output ports
  dmrc_delay_line #(.W(SAMPLE_W), .N(DATA_PIPE_STAGES)) u_data_pipe (
    .clk(clk),
    .nrst(nrst),
    .din(sample_in),
    .dout(dly_out)
  );

  // divider, data-ready clock and reset driver next values
  always_comb begin
    nxt_div_cnt = div_cnt_ff + 2'h1;
    if (rst_pipe) begin
      // first reset cycle snaps to the known phase, later ones keep bit 0 toggling
      // so the data-ready clock runs on while reset is out [RULE6] [RULE13]
      nxt_div_cnt = rst_out_ff ? {1'b0, ~div_cnt_ff[0]} : DIV_RST_PHASE;
    end
    // without any reset the half clock phase is whatever the counter holds [RULE12]
    // an idle low reset pin never reaches this branch [RULE5]
    case (mode_ff)
      DMRC_FULL: begin
        // a flop cannot toggle at clk rate; clock held high, strobe marks updates
        upd = 1'b1;
        nxt_dr_clk = 1'b1;
      end
      DMRC_HALF: begin
        upd = div_cnt_ff[0];
        nxt_dr_clk = div_cnt_ff[0]; // [RULE11]
      end
      DMRC_QUARTER: begin
        upd = &div_cnt_ff;
        nxt_dr_clk = ~(div_cnt_ff[1] ^ div_cnt_ff[0]); // [RULE11]
      end
      default: begin
        upd = 1'b1;
        nxt_dr_clk = 1'b1;
      end
    endcase
    nxt_rst_out = rst_pipe; // last stage after clock generator [RULE7] [RULE10]
  end

  // divider registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_ff <= DIV_CNT_RST;
      dr_clk_ff <= 1'b0;
      rst_out_ff <= 1'b0;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
      dr_clk_ff <= nxt_dr_clk;
      rst_out_ff <= nxt_rst_out;
    end
  end

  // output words load only with a data-ready rise, or every cycle at full rate [RULE3]
  always_comb begin
    nxt_prev1 = dly_out;
    nxt_prev2 = prev1_ff;
    nxt_prim = prim_ff;
    nxt_aux = aux_ff;
    nxt_strobe = upd;
    if (upd) begin
      nxt_prim = dly_out;
      case (mode_ff)
        DMRC_FULL: begin
          nxt_aux = prim_ff; // auxiliary repeats primary one cycle late
        end
        DMRC_HALF: begin
          nxt_aux = prev1_ff; // older sample on auxiliary [RULE1] [RULE16]
        end
        DMRC_QUARTER: begin
          nxt_aux = prev2_ff; // sample between is discarded [RULE17]
        end
        default: begin
          nxt_aux = prev1_ff;
        end
      endcase
    end
  end

  // output word registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev1_ff <= DATA_RST;
      prev2_ff <= DATA_RST;
      prim_ff <= DATA_RST;
      aux_ff <= DATA_RST;
      strobe_ff <= 1'b0;
    end else begin
      prev1_ff <= nxt_prev1;
      prev2_ff <= nxt_prev2;
      prim_ff <= nxt_prim;
      aux_ff <= nxt_aux;
      strobe_ff <= nxt_strobe;
    end
  end

  // settle counter for the checks only
  always_comb begin
    nxt_quiet = (quiet_ff == QUIET_MAX) ? quiet_ff : quiet_ff + 3'h1;
    if (rst_pipe || mode_chg) begin
      nxt_quiet = 3'h0;
    end
  end

  // settle counter register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      quiet_ff <= 3'h0;
    end else begin
      quiet_ff <= nxt_quiet;
    end
  end

  assign primary_data = prim_ff;
  assign aux_data = aux_ff;
  assign data_ready_clock_out = dr_clk_ff;
  assign data_ready_strobe = strobe_ff;
  assign aligned_reset_out = rst_out_ff;

  // reset out lags the second latch stage by the pipe plus driver
  a_reset_out_lat: assert property (@(posedge clk) disable iff (!nrst) // [RULE8]
    ##5 (aligned_reset_out == $past(rst_s2_ff, 5)))
    else $error("reset output latency wrong");

  // reset out rises six cycles after the first latch stage, one cycle before primary data
  a_reset_lead: assert property (@(posedge clk) disable iff (!nrst) // [RULE18]
    $rose(rst_s1_ff) |-> ##6 $rose(aligned_reset_out))
    else $error("reset output not 7 cycles after pin");

  // known divider phase after a reset edge
  a_phase_known: assert property (@(posedge clk) disable iff (!nrst) // [RULE13]
    (rst_pipe && !rst_out_ff) |=> (div_cnt_ff == DIV_RST_PHASE))
    else $error("divider not forced to reset phase");

  // strobe marks a rising data-ready edge outside full rate
  a_strobe_rise: assert property (@(posedge clk) disable iff (!nrst) // [RULE3]
    // current and previous clock come from different mode cycles, so two stable cycles are needed
    (data_ready_strobe && mode_ff != DMRC_FULL && $past(mode_ff) == mode_ff && $past(mode_ff, 2) == mode_ff)
      |-> (data_ready_clock_out && !$past(data_ready_clock_out)))
    else $error("data update without data-ready rise");

  // ports stay put between data-ready rises
  a_data_hold: assert property (@(posedge clk) disable iff (!nrst) // [RULE3]
    !data_ready_strobe |-> ($stable(primary_data) && $stable(aux_data)))
    else $error("output data changed off a data-ready rise");

  // half rate: auxiliary older, primary newer
  a_half_order: assert property (@(posedge clk) disable iff (!nrst) // [RULE16]
    (quiet_ff == QUIET_MAX && mode_ff == DMRC_HALF && data_ready_strobe)
      |-> (primary_data == $past(dly_out) && aux_data == $past(dly_out, 2)))
    else $error("half rate port order wrong");

  // quarter rate: skipped sample between ports
  a_quarter_skip: assert property (@(posedge clk) disable iff (!nrst) // [RULE17]
    (quiet_ff == QUIET_MAX && mode_ff == DMRC_QUARTER && data_ready_strobe)
      |-> (primary_data == $past(dly_out) && aux_data == $past(dly_out, 3)))
    else $error("quarter rate decimation wrong");

  // quarter rate updates every fourth cycle
  a_quarter_period: assert property (@(posedge clk) disable iff (!nrst || rst_pipe || mode_chg) // [RULE11]
    (quiet_ff == QUIET_MAX && mode_ff == DMRC_QUARTER && data_ready_strobe)
      |=> !data_ready_strobe [*3] ##1 data_ready_strobe)
    else $error("quarter rate period wrong");

  // half rate updates every other cycle
  a_half_period: assert property (@(posedge clk) disable iff (!nrst || mode_chg) // [RULE1]
    // a realigning reset may swallow one cycle right after its first cycle
    (quiet_ff == QUIET_MAX && mode_ff == DMRC_HALF && data_ready_strobe && !rst_pipe)
      |=> !data_ready_strobe ##1 data_ready_strobe)
    else $error("half rate period wrong");

  // mode follows the synchronised pins
  a_mode_decode: assert property (@(posedge clk) disable iff (!nrst) // [RULE15]
    ##1 (mode_ff == dmrc_decode_mode($past(split_s2_ff), $past(rate_s2_ff))))
    else $error("mode decode wrong");
endmodule : dmrc_demux_clock
`default_nettype wire

// *** logic/dmrc_pkg.sv ***
// constants, mode type and mode decode for the demux reset and rate clock block
`default_nettype none
package dmrc_pkg;
  localparam int SAMPLE_W = 8; // converter word width
  localparam int SYNC_STAGES = 2; // pin synchroniser depth, the reset input dual latch
  localparam int PRIMARY_LAT_CYC = 8; // 7.5 sample clocks rounded up to whole cycles
  localparam int RST_OUT_LAT_CYC = PRIMARY_LAT_CYC - 1; // reset leads primary data by one cycle
  localparam int RST_PIPE_STAGES = RST_OUT_LAT_CYC - SYNC_STAGES - 1; // latch and driver stages excluded
  localparam int DATA_PIPE_STAGES = PRIMARY_LAT_CYC - 1; // output register adds the last cycle
  localparam logic [1:0] DIV_CNT_RST = 2'h0; // divider value after nrst
  localparam logic [1:0] DIV_RST_PHASE = 2'h0; // known phase forced by a sync reset
  localparam logic [SAMPLE_W-1:0] DATA_RST = 8'h00; // output words after nrst
  localparam logic [2:0] QUIET_MAX = 3'h7; // settle count used by checks

  // output rate modes, one-hot
  typedef enum logic [2:0] {
    DMRC_FULL = 3'b001,
    DMRC_HALF = 3'b010,
    DMRC_QUARTER = 3'b100
  } dmrc_mode_t;

  // split low gives full rate whatever rate select is
  function automatic dmrc_mode_t dmrc_decode_mode(input logic split, input logic rate);
    if (!split) begin
      return DMRC_FULL;
    end else if (!rate) begin
      return DMRC_HALF;
    end
    return DMRC_QUARTER;
  endfunction : dmrc_decode_mode
endpackage : dmrc_pkg
`default_nettype wire

// *** logic/dmrc_delay_line.sv ***
// fixed-depth shift register used for the data and reset pipelines
`timescale 1ns/1ps
`default_nettype none
module dmrc_delay_line #(
  parameter int W = 1,
  parameter int N = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage_ff [N]; // one word per stage
  logic [W-1:0] nxt_stage [N]; // shifted values

  // each stage takes the one before it
  generate
    for (genvar i = 0; i < N; i++) begin : g_stage
      always_comb begin
        if (i == 0) begin
          nxt_stage[i] = din;
        end else begin
          nxt_stage[i] = stage_ff[(i > 0) ? i - 1 : 0];
        end
      end

      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          stage_ff[i] <= '0;
        end else begin
          stage_ff[i] <= nxt_stage[i];
        end
      end
    end
  endgenerate

  assign dout = stage_ff[N-1];
endmodule : dmrc_delay_line
`default_nettype wire

// *** testbench/dmrc_reset_ctrl.sv ***
// partner model: controller that drives the sync reset pin
`timescale 1ns/1ps
`default_nettype none
module dmrc_reset_ctrl (
  input wire logic clk,
  input wire logic nrst,
  input wire logic rst_req, // bench request, level
  output logic sync_reset_in
);
  logic [2:0] pup_ff; // power-up burst counter
  logic [2:0] nxt_pup;
  // one burst after power-up so every converter shares a phase
  always_comb begin
    nxt_pup = (pup_ff != 3'h4) ? pup_ff + 3'h1 : pup_ff;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pup_ff <= 3'h0;
    end else begin
      pup_ff <= nxt_pup;
    end
  end
  // moves only just after rising edges, so setup and hold hold
  assign sync_reset_in = rst_req | (pup_ff != 3'h4);
endmodule : dmrc_reset_ctrl
`default_nettype wire

// *** testbench/dmrc_demux_clock_tb.sv ***
// self-checking bench for the demux rate clock and reset path
`timescale 1ns/1ps
`default_nettype none
module dmrc_demux_clock_tb;
  import dmrc_pkg::*;
  logic clk, nrst, rst_req, sync_reset_in, split_enable, rate_select;
  logic [SAMPLE_W-1:0] sample_in, primary_data, aux_data; // counting stream
  logic data_ready_clock_out, data_ready_strobe, aligned_reset_out;
  int failures, n_compared, ph_a, ph_b; // verdict counters, phases
  dmrc_demux_clock dut (.clk(clk), .nrst(nrst), .sample_in(sample_in), .sync_reset_in(sync_reset_in),
    .split_enable(split_enable), .rate_select(rate_select), .primary_data(primary_data),
    .aux_data(aux_data), .data_ready_clock_out(data_ready_clock_out),
    .data_ready_strobe(data_ready_strobe), .aligned_reset_out(aligned_reset_out));
  dmrc_reset_ctrl ctrl (.clk(clk), .nrst(nrst), .rst_req(rst_req), .sync_reset_in(sync_reset_in));
  // 200 MHz sample clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // each word names the edge it was taken at, so latency shows directly
  // single driver: cleared while nrst is low, counts afterwards
  always @(posedge clk) sample_in <= nrst ? sample_in + 8'h01 : 8'h00;
  task automatic check_word(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check_word
  task automatic check_cnt(input int got, input int exp, input string msg);
    n_compared++;
    if (got != exp) begin
      failures++;
      $display("wrong value at %0t: %s got %0d exp %0d", $time, msg, got, exp);
    end
  endtask : check_cnt
  task automatic check_vec(input logic [11:0] got, input logic [11:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check_vec
  // bounded wait for the next update marker, returns cycles taken
  task automatic next_strobe(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (data_ready_strobe !== 1'b1 && n < 20);
  endtask : next_strobe
  // set a mode, let the pin synchronisers settle, then judge six updates
  task automatic test_mode(input logic sp, input logic rs, input int per, input logic [7:0] aux_off);
    int n;
    @(posedge clk);
    split_enable <= sp;
    rate_select <= rs;
    repeat (16) @(posedge clk);
    next_strobe(n);
    for (int i = 0; i < 6; i++) begin
      next_strobe(n);
      check_cnt(n, per, "update period");
      check_word(primary_data, sample_in - 8'(PRIMARY_LAT_CYC), "primary latency");
      check_word(aux_data, primary_data - aux_off, "aux word");
      check_word({7'h00, data_ready_clock_out}, 8'h01, "clock at update");
      check_word({7'h00, aligned_reset_out}, 8'h00, "idle reset out");
    end
    $display("test done: mode split %b rate %b", sp, rs);
  endtask : test_mode
  // three-cycle reset pulse: edge D raises the pin, out high after D+7..D+9
  task automatic test_reset(input int lead, output int ph);
    logic [11:0] seen;
    int n;
    seen = 12'h000;
    n = 0;
    repeat (lead + 1) @(posedge clk);
    rst_req <= 1'b1;
    for (int i = 1; i <= 11; i++) begin
      @(posedge clk);
      if (i == 3) begin
        rst_req <= 1'b0;
      end
      #1;
      seen[i] = aligned_reset_out;
      n += (data_ready_strobe === 1'b1 && aligned_reset_out === 1'b1) ? 1 : 0;
    end
    check_vec(seen, 12'h380, "reset out timing");
    check_cnt(n > 0, 1, "clock runs in reset");
    next_strobe(ph);
    $display("test done: reset pulse lead %0d", lead);
  endtask : test_reset
  // summary, verdict and end of run
  task automatic wrap_up();
    $display("counts: %0d compared, %0d wrong", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  // main sequence
  initial begin
    failures = 0;
    n_compared = 0;
    nrst = 1'b0;
    rst_req = 1'b0;
    split_enable = 1'b0;
    rate_select = 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    test_mode(1'b0, 1'b0, 1, 8'h01);
    test_mode(1'b0, 1'b1, 1, 8'h01);
    test_mode(1'b1, 1'b1, 4, 8'h02);
    test_mode(1'b1, 1'b0, 2, 8'h01);
    test_reset(0, ph_a);
    test_reset(1, ph_b);
    check_cnt(ph_a, ph_b, "phase after reset");
    wrap_up();
  end
  // watchdog, well beyond the roughly 160 cycles the tests need
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    wrap_up();
  end
endmodule : dmrc_demux_clock_tb
`default_nettype wire
